//--- scm_defines.vh
`ifndef SCM_DEFINES_VH
`define SCM_DEFINES_VH
// Behaviour
// - Host sets trigger bit, device clears when done
// - Reset bit7, restore bit6, flash update bit3
// - Software reset reloads registers, restarts sampling
// - Self-test bit1 records per-sensor pass/fail result
// - Self-test takes 12 ms, 35 ms externally clocked
// - Flash write count readable as two words
// - Restore, update, bias null each bump counter
// - Flash test bit2 writes error flag bit6
// - Each line carries exactly one function
// - Conflicting lower-priority enable is cleared automatically
// - Alarm: enable 11, polarity 10, line 9:8
// - Sync: enable 7, edge 6, line 5:4
// - Data-ready: enable 3, polarity 2, line 1:0
// - Line select code 00..11 means lines 1..4
// - Function control resets to 0x000d
// - Sync enable stops internal sampling clock
// - General bits 3:0 set line direction
// - General bits 7:4 read pins, write levels
// - Level bits of general outputs read back, upper byte ignored

// ********
// Clock and operation times
// ********
`define SCM_CLK_HZ 10000000
`define SCM_CYC_PER_MS (`SCM_CLK_HZ / 1000)
`define SCM_T_SWRST_MS 120
`define SCM_T_FACT_MS 75
`define SCM_T_FLUPD_MS 375
`define SCM_T_FLTST_MS 50
`define SCM_T_STEST_MS 12
`define SCM_T_STEXT_MS 35
`define SCM_T_BIAS_MS 375

// ********
// Pages and byte addresses
// ********
`define SCM_PG_STATUS 8'h00
`define SCM_PG_FLASH 8'h02
`define SCM_PG_CTRL 8'h03
`define SCM_A_PAGE 7'h00
`define SCM_A_CMD 7'h02
`define SCM_A_FNC 7'h06
`define SCM_A_GPIO 7'h08
`define SCM_A_SYSERR 7'h08
`define SCM_A_DIAG 7'h0a
`define SCM_A_FCNT_LO 7'h7c
`define SCM_A_FCNT_HI 7'h7e

// ********
// Command bits and field layout
// ********
`define SCM_CMD_SWRST 3'h7
`define SCM_CMD_FACT 3'h6
`define SCM_CMD_FLUPD 3'h3
`define SCM_CMD_FLTST 3'h2
`define SCM_CMD_STEST 3'h1
`define SCM_CMD_BIAS 3'h0
`define SCM_CMD_MASK 8'hcf
`define SCM_FNC_RST 16'h000d
`define SCM_FNC_MASK 16'h0fff
`define SCM_FNC_AL_EN 11
`define SCM_FNC_AL_POL 10
`define SCM_FNC_AL_SEL 9:8
`define SCM_FNC_SY_EN 7
`define SCM_FNC_SY_EDGE 6
`define SCM_FNC_SY_SEL 5:4
`define SCM_FNC_DR_EN 3
`define SCM_FNC_DR_POL 2
`define SCM_FNC_DR_SEL 1:0
`define SCM_OWN_GPIO 2'h0
`define SCM_OWN_DRDY 2'h1
`define SCM_OWN_SYNC 2'h2
`define SCM_OWN_ALRM 2'h3
`define SCM_SYSERR_FLASH 6
`endif

//--- scm_spi_slave.v
`timescale 1ns/1ns
`default_nettype none
// ********
// Serial link slave, clock idles high
// ********
module scm_spi_slave (
  input wire clk,
  input wire rst,
  input wire sclk,
  input wire cs_n,
  input wire mosi,
  input wire [15:0] tx_word,
  output reg miso_q,
  output reg miso_oe_n_q,
  output reg rx_valid_q,
  output reg [15:0] rx_word_q
);
  // Synchroniser chains; stage 2 against 1 gives edges
  reg [2:0] sclk_s_q;
  reg [2:0] cs_s_q;
  reg [1:0] mosi_s_q;
  reg [15:0] tx_sh_q; // Outgoing word
  reg [3:0] bit_q; // Bits taken this frame
  reg [1:0] reload_q; // Waits for the answer to settle
  wire sel = ~cs_s_q[1];
  wire rise = sclk_s_q[1] & ~sclk_s_q[2];
  wire fall = ~sclk_s_q[1] & sclk_s_q[2];
  wire cs_fall = ~cs_s_q[1] & cs_s_q[2];

  // Shift in on rising edges, shift out on falling edges
  always @(posedge clk) begin
    if (rst) begin
      sclk_s_q <= 3'h7;
      cs_s_q <= 3'h7;
      mosi_s_q <= 2'h0;
      tx_sh_q <= 16'h0000;
      bit_q <= 4'h0;
      reload_q <= 2'h0;
      miso_q <= 1'b0;
      miso_oe_n_q <= 1'b1;
      rx_valid_q <= 1'b0;
      rx_word_q <= 16'h0000;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], sclk};
      cs_s_q <= {cs_s_q[1:0], cs_n};
      mosi_s_q <= {mosi_s_q[0], mosi};
      miso_oe_n_q <= ~sel;
      rx_valid_q <= 1'b0;
      reload_q <= {reload_q[0], 1'b0};
      // Reload two cycles after a frame so the answer is ready
      if (cs_fall || reload_q[1]) begin
        tx_sh_q <= tx_word;
      end else if (sel && fall) begin
        miso_q <= tx_sh_q[15];
        tx_sh_q <= {tx_sh_q[14:0], 1'b0};
      end
      if (!sel) begin
        bit_q <= 4'h0;
      end else if (rise) begin
        rx_word_q <= {rx_word_q[14:0], mosi_s_q[1]};
        bit_q <= bit_q + 4'h1;
        if (bit_q == 4'hf) begin
          rx_valid_q <= 1'b1;
          reload_q <= 2'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- scm_op_timer.v
`timescale 1ns/1ns
`default_nettype none
// ********
// Operation run timer
// ********
module scm_op_timer (
  input wire clk,
  input wire rst,
  input wire start,
  input wire [31:0] len,
  output reg busy_q,
  output reg done_q,
  output reg [31:0] rem_q
);
  // Counts len cycles down to zero, then pulses done
  always @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rem_q <= 32'h0;
    end else begin
      done_q <= 1'b0;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
        rem_q <= (len == 32'h0) ? 32'h0 : len - 32'h1;
      end else if (busy_q) begin
        if (rem_q == 32'h0) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          rem_q <= rem_q - 32'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- scm_top.v
`timescale 1ns/1ns
`default_nettype none
`include "scm_defines.vh"
// ********
// System control and line function mux
// ********
module scm_top #(
  parameter [31:0] CYC_PER_MS = `SCM_CYC_PER_MS,
  parameter [31:0] SWRST_CYC = `SCM_T_SWRST_MS * CYC_PER_MS,
  parameter [31:0] FACT_CYC = `SCM_T_FACT_MS * CYC_PER_MS,
  parameter [31:0] FLUPD_CYC = `SCM_T_FLUPD_MS * CYC_PER_MS,
  parameter [31:0] FLTST_CYC = `SCM_T_FLTST_MS * CYC_PER_MS,
  parameter [31:0] STEST_CYC = `SCM_T_STEST_MS * CYC_PER_MS,
  parameter [31:0] STEXT_CYC = `SCM_T_STEXT_MS * CYC_PER_MS,
  parameter [31:0] BIAS_CYC = `SCM_T_BIAS_MS * CYC_PER_MS,
  parameter [15:0] SAMPLE_DIV = 16'h1000,
  parameter [7:0] DRDY_W = 8'h20
) (
  input wire clk,
  input wire rst,
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_mosi,
  output wire spi_miso,
  output wire spi_miso_oe_n,
  input wire [3:0] line_in,
  output wire [3:0] line_out,
  output wire [3:0] line_oe_n,
  input wire alarm_active,
  input wire [15:0] st_fail,
  input wire flash_sum_ok,
  output wire sample_tick,
  output wire st_excite,
  output wire data_flush
);

  // ********
  // Functions
  // ********

  // Drop lower-priority enables that share a line
  function [15:0] scm_resolve;
    input [15:0] f;
    reg [15:0] r;
    begin
      r = f & `SCM_FNC_MASK;
      if (r[`SCM_FNC_DR_EN] && r[`SCM_FNC_SY_EN] &&
          r[`SCM_FNC_DR_SEL] == r[`SCM_FNC_SY_SEL])
        r[`SCM_FNC_SY_EN] = 1'b0;
      if (r[`SCM_FNC_AL_EN] &&
          ((r[`SCM_FNC_DR_EN] && r[`SCM_FNC_DR_SEL] == r[`SCM_FNC_AL_SEL]) ||
           (r[`SCM_FNC_SY_EN] && r[`SCM_FNC_SY_SEL] == r[`SCM_FNC_AL_SEL])))
        r[`SCM_FNC_AL_EN] = 1'b0;
      scm_resolve = r;
    end
  endfunction

  // Which single function owns line i
  function [1:0] scm_owner;
    input [15:0] f;
    input [1:0] i;
    begin
      if (f[`SCM_FNC_DR_EN] && f[`SCM_FNC_DR_SEL] == i)
        scm_owner = `SCM_OWN_DRDY;
      else if (f[`SCM_FNC_SY_EN] && f[`SCM_FNC_SY_SEL] == i)
        scm_owner = `SCM_OWN_SYNC;
      else if (f[`SCM_FNC_AL_EN] && f[`SCM_FNC_AL_SEL] == i)
        scm_owner = `SCM_OWN_ALRM;
      else
        scm_owner = `SCM_OWN_GPIO;
    end
  endfunction

  // Highest pending command goes first, reset above all
  function [2:0] scm_pick;
    input [7:0] p;
    integer k;
    begin
      scm_pick = 3'h0;
      for (k = 0; k < 8; k = k + 1)
        if (p[k])
          scm_pick = k[2:0];
    end
  endfunction

  // ********
  // State
  // ********
  reg [7:0] page_q; // Selected register page
  reg [7:0] pend_q; // Trigger bits pending or running
  reg [15:0] fnc_q; // Line function control
  reg [3:0] dir_q; // General line direction
  reg [3:0] lvl_q; // General line driven level
  reg [15:0] fl_fnc_q; // Flash copy of function control
  reg [3:0] fl_dir_q; // Flash copy of direction
  reg [31:0] fcnt_q; // Flash write count
  reg [15:0] diag_q; // Self-test results
  reg flfail_q; // Flash checksum failed
  reg [15:0] rsp_q; // Answer for the next frame
  reg run_q; // An operation is running
  reg start_q; // Timer start pulse
  reg [2:0] op_q; // Running command bit
  reg [31:0] len_d; // Duration of that command
  reg [15:0] rd_d; // Read mux
  reg [3:0] ls1_q; // Line synchroniser stage 1
  reg [3:0] ls2_q; // Line synchroniser stage 2
  reg sy_prev_q; // Previous sync line level
  reg [15:0] div_q; // Internal sample divider
  reg tick_q; // Sample strobe
  reg [7:0] drdy_cnt_q; // Data-ready active time left
  reg [3:0] lo_q; // Line output levels
  reg [3:0] oe_q; // Line output enables, low drives
  reg exc_q; // Self-excitation on
  reg flush_q; // Data discard pulse
  wire rx_valid;
  wire [15:0] rx_word;
  wire t_busy;
  wire t_done;
  wire [31:0] t_rem;
  wire [3:0] lo_d;
  wire [3:0] oe_d;
  wire [3:0] lvl_rd;

  // ********
  // Link and timer
  // ********
  scm_spi_slave u_spi (
    .clk(clk),
    .rst(rst),
    .sclk(spi_sclk),
    .cs_n(spi_cs_n),
    .mosi(spi_mosi),
    .tx_word(rsp_q),
    .miso_q(spi_miso),
    .miso_oe_n_q(spi_miso_oe_n),
    .rx_valid_q(rx_valid),
    .rx_word_q(rx_word)
  );

  scm_op_timer u_tmr (
    .clk(clk),
    .rst(rst),
    .start(start_q),
    .len(len_d),
    .busy_q(t_busy),
    .done_q(t_done),
    .rem_q(t_rem)
  );

  // Frame decode: bit 15 marks a byte write
  wire wr = rx_valid & rx_word[15];
  wire [6:0] addr = rx_word[14:8];
  wire [7:0] wdat = rx_word[7:0];
  wire [6:0] wa = {addr[6:1], 1'b0};
  wire pg3 = page_q == `SCM_PG_CTRL;
  wire [7:0] cmd_set = (wr && pg3 && addr == `SCM_A_CMD) ?
                       (wdat & `SCM_CMD_MASK) : 8'h00;
  wire sy_en = fnc_q[`SCM_FNC_SY_EN];
  wire rst_run = run_q && op_q == `SCM_CMD_SWRST;
  wire d_rst = t_done && op_q == `SCM_CMD_SWRST;
  wire d_fl = t_done && (op_q == `SCM_CMD_FACT ||
              op_q == `SCM_CMD_FLUPD || op_q == `SCM_CMD_BIAS);
  wire [7:0] clr = t_done ? (8'h01 << op_q) : 8'h00;

  // ********
  // Command sequencer
  // ********

  // Duration of the running command
  always @* begin
    case (op_q)
      `SCM_CMD_SWRST: len_d = SWRST_CYC;
      `SCM_CMD_FACT: len_d = FACT_CYC;
      `SCM_CMD_FLUPD: len_d = FLUPD_CYC;
      `SCM_CMD_FLTST: len_d = FLTST_CYC;
      `SCM_CMD_STEST: len_d = sy_en ? STEXT_CYC : STEST_CYC;
      default: len_d = BIAS_CYC;
    endcase
  end

  // One operation at a time; others wait pending
  always @(posedge clk) begin
    if (rst) begin
      run_q <= 1'b0;
      start_q <= 1'b0;
      op_q <= 3'h0;
      exc_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (!run_q && pend_q != 8'h00) begin
        op_q <= scm_pick(pend_q);
        run_q <= 1'b1;
        start_q <= 1'b1;
      end else if (t_done) begin
        run_q <= 1'b0;
      end
      // Excitation in the second half: off-measure, then on-measure
      exc_q <= t_busy && op_q == `SCM_CMD_STEST &&
               t_rem < {1'b0, len_d[31:1]};
    end
  end

  // ********
  // Register bank
  // ********

  // Host writes, command effects and reset reload
  always @(posedge clk) begin
    if (rst) begin
      page_q <= `SCM_PG_STATUS;
      pend_q <= 8'h00;
      fnc_q <= `SCM_FNC_RST;
      dir_q <= 4'h0;
      lvl_q <= 4'h0;
      fl_fnc_q <= `SCM_FNC_RST;
      fl_dir_q <= 4'h0;
      fcnt_q <= 32'h0;
      diag_q <= 16'h0000;
      flfail_q <= 1'b0;
    end else begin
      // New trigger wins over the clear of the same bit
      pend_q <= (pend_q & ~clr) | cmd_set;
      if (wr && addr == `SCM_A_PAGE)
        page_q <= wdat;
      if (wr && pg3) begin
        // Byte writes land at once; each resolves against the other byte as it stands, so order matters
        case (addr)
          `SCM_A_FNC: fnc_q <= scm_resolve({fnc_q[15:8], wdat});
          `SCM_A_FNC + 7'h01: fnc_q <= scm_resolve({wdat, fnc_q[7:0]});
          `SCM_A_GPIO: begin
            dir_q <= wdat[3:0];
            lvl_q <= wdat[7:4];
          end
          default: ; // Upper gpio byte ignored
        endcase
      end
      if (d_fl)
        fcnt_q <= fcnt_q + 32'h1;
      if (t_done && op_q == `SCM_CMD_FLUPD) begin
        fl_fnc_q <= fnc_q;
        fl_dir_q <= dir_q;
      end
      if (t_done && op_q == `SCM_CMD_FACT) begin
        fl_fnc_q <= `SCM_FNC_RST;
        fl_dir_q <= 4'h0;
      end
      if (t_done && op_q == `SCM_CMD_FLTST)
        flfail_q <= ~flash_sum_ok;
      if (t_done && op_q == `SCM_CMD_STEST)
        diag_q <= st_fail;
      // Software reset: reload from flash, drop results
      if (d_rst) begin
        page_q <= `SCM_PG_STATUS;
        fnc_q <= scm_resolve(fl_fnc_q);
        dir_q <= fl_dir_q;
        lvl_q <= 4'h0;
        diag_q <= 16'h0000;
        flfail_q <= 1'b0;
      end
    end
  end

  // Read mux, word address with bit 0 ignored
  always @* begin
    rd_d = 16'h0000;
    if (wa == `SCM_A_PAGE)
      rd_d = {8'h00, page_q};
    else if (page_q == `SCM_PG_STATUS && wa == `SCM_A_SYSERR)
      rd_d = {9'h000, flfail_q, 6'h00};
    else if (page_q == `SCM_PG_STATUS && wa == `SCM_A_DIAG)
      rd_d = diag_q;
    else if (page_q == `SCM_PG_FLASH && wa == `SCM_A_FCNT_LO)
      rd_d = fcnt_q[15:0];
    else if (page_q == `SCM_PG_FLASH && wa == `SCM_A_FCNT_HI)
      rd_d = fcnt_q[31:16];
    else if (pg3 && wa == `SCM_A_CMD)
      rd_d = {8'h00, pend_q};
    else if (pg3 && wa == `SCM_A_FNC)
      rd_d = fnc_q;
    else if (pg3 && wa == `SCM_A_GPIO)
      rd_d = {8'h00, lvl_rd, dir_q};
  end

  // Answer is latched at frame end, shifted out next frame
  always @(posedge clk) begin
    if (rst)
      rsp_q <= 16'h0000;
    else if (rx_valid)
      rsp_q <= rx_word[15] ? 16'h0000 : rd_d;
  end

  // ********
  // Sampling and data-ready
  // ********

  // Line pins cross into the clock domain
  always @(posedge clk) begin
    if (rst) begin
      ls1_q <= 4'h0;
      ls2_q <= 4'h0;
    end else begin
      ls1_q <= line_in;
      ls2_q <= ls1_q;
    end
  end

  wire sy_lvl = ls2_q[fnc_q[`SCM_FNC_SY_SEL]];
  wire sy_edge = fnc_q[`SCM_FNC_SY_EDGE] ? (sy_lvl & ~sy_prev_q) :
                 (~sy_lvl & sy_prev_q);

  // Sample strobe from divider or external edge
  always @(posedge clk) begin
    if (rst) begin
      sy_prev_q <= 1'b0;
      div_q <= 16'h0000;
      tick_q <= 1'b0;
      drdy_cnt_q <= 8'h00;
      flush_q <= 1'b0;
    end else begin
      sy_prev_q <= sy_lvl;
      flush_q <= d_rst;
      tick_q <= 1'b0;
      // Divider halts under sync so no stray samples come
      if (sy_en || rst_run || div_q == SAMPLE_DIV - 16'h1)
        div_q <= 16'h0000;
      else
        div_q <= div_q + 16'h1;
      if (!rst_run)
        tick_q <= sy_en ? sy_edge : (div_q == SAMPLE_DIV - 16'h1);
      // Data-ready stands for a fixed time after each sample
      if (rst_run)
        drdy_cnt_q <= 8'h00;
      else if (tick_q)
        drdy_cnt_q <= DRDY_W;
      else if (drdy_cnt_q != 8'h00)
        drdy_cnt_q <= drdy_cnt_q - 8'h01;
    end
  end

  wire drdy_act = drdy_cnt_q != 8'h00;

  // ********
  // Line function mux
  // ********
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_line
      wire [1:0] own = scm_owner(fnc_q, g[1:0]);
      wire gp = own == `SCM_OWN_GPIO;
      // General output lines read back their level, others the pin
      assign lvl_rd[g] = (gp && dir_q[g]) ? lvl_q[g] : ls2_q[g];
      assign lo_d[g] = (own == `SCM_OWN_DRDY) ?
                       (drdy_act ~^ fnc_q[`SCM_FNC_DR_POL]) :
                       (own == `SCM_OWN_ALRM) ?
                       (alarm_active ~^ fnc_q[`SCM_FNC_AL_POL]) :
                       lvl_q[g];
      assign oe_d[g] = (own == `SCM_OWN_SYNC) ? 1'b1 :
                       gp ? ~dir_q[g] : 1'b0;
    end
  endgenerate

  // Pin drivers registered
  always @(posedge clk) begin
    if (rst) begin
      lo_q <= 4'h0;
      oe_q <= 4'hf;
    end else begin
      lo_q <= lo_d;
      oe_q <= oe_d;
    end
  end

  assign line_out = lo_q;
  assign line_oe_n = oe_q;
  assign sample_tick = tick_q;
  assign st_excite = exc_q;
  assign data_flush = flush_q;
endmodule
`default_nettype wire

//--- scm_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Host link master model
// ****
module scm_host_model (
  input wire logic clk,
  input wire logic miso,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  // Link idle: clock high, not selected
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // One 16-bit frame, MSB first; half period is four clocks
  task automatic xfer(input logic [15:0] din, output logic [15:0] dout);
    dout = 16'h0000;
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      sclk <= 1'b0;
      mosi <= din[i];
      repeat (4) @(posedge clk);
      dout = {dout[14:0], miso};
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
    end
    cs_n <= 1'b1;
    // Released data line shows no stale level
    mosi <= ~mosi;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- scm_top_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Port checker
// ****
module scm_top_chk #(
  parameter [31:0] STEXT_CYC = 32'd900
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic spi_cs_n,
  input wire logic spi_miso_oe_n,
  input wire logic [3:0] line_out,
  input wire logic [3:0] line_oe_n,
  input wire logic sample_tick,
  input wire logic st_excite,
  input wire logic data_flush
);
  // Longest excitation phase plus slack
  localparam int EXC_MAX = int'(STEXT_CYC) / 2 + 8;
  // Select history, covers the synchroniser delay
  logic [5:0] cs_q;
  always @(posedge clk) begin
    cs_q <= {cs_q[4:0], spi_cs_n};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  rst_vals_a: assert property (
    $fell(rst) |-> line_oe_n == 4'hf && spi_miso_oe_n && !sample_tick && !st_excite
      && !data_flush ##[1:3] line_oe_n == 4'hd) else $error("reset state wrong");
  flush_pulse_a: assert property (
    data_flush |=> !data_flush) else $error("flush not one cycle");
  excite_span_a: assert property (
    $rose(st_excite) |-> st_excite[*8] ##[0:EXC_MAX] !st_excite)
    else $error("excitation span wrong");
  tick_pulse_a: assert property (
    sample_tick |=> !sample_tick) else $error("tick not one cycle");
  drdy_width_a: assert property (
    $rose(line_out[1]) && line_oe_n == 4'hd && $past(sample_tick, 2) |-> line_out[1][*8])
    else $error("ready pulse short");
  drdy_follow_a: assert property (
    sample_tick && line_oe_n == 4'hd && !line_out[1] |-> ##[1:3] line_out[1])
    else $error("ready not after tick");
  oe_off_a: assert property (
    cs_q == 6'h3f |-> spi_miso_oe_n) else $error("miso driven unselected");
  oe_on_a: assert property (
    cs_q == 6'h00 |-> !spi_miso_oe_n) else $error("miso not driven");
  cover property ($rose(st_excite));
  cover property (data_flush);
  cover property ($fell(spi_cs_n));
endmodule
bind scm_top scm_top_chk #(.STEXT_CYC(STEXT_CYC)) chk (.clk(clk), .rst(rst),
  .spi_cs_n(spi_cs_n), .spi_miso_oe_n(spi_miso_oe_n), .line_out(line_out),
  .line_oe_n(line_oe_n), .sample_tick(sample_tick), .st_excite(st_excite),
  .data_flush(data_flush));
`default_nettype wire

//--- tb_system_control_and_dio_mux.sv
`timescale 1ns/1ns
`default_nettype none
`include "scm_defines.vh"
module tb_system_control_and_dio_mux;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic alarm_active = 1'b0;
  logic flash_sum_ok = 1'b1;
  logic [15:0] st_fail = 16'h00a5;
  logic [3:0] pin_drv = 4'h0;
  logic sclk;
  logic cs_n;
  logic mosi;
  wire miso;
  wire miso_oe_n;
  wire tick;
  wire excite;
  wire flush;
  wire [3:0] lout;
  wire [3:0] loe_n;
  // Pin level: device where it drives, else the outside source
  wire [3:0] lin = (~loe_n & lout) | (loe_n & pin_drv);
  int err_count = 0;
  int checked = 0;
  int ticks = 0;
  int n;
  logic [15:0] r;
  logic [7:0] ops [4] = '{8'h40, 8'h08, 8'h01, 8'h04};
  always #50 clk = ~clk;
  always @(negedge clk) if (tick === 1'b1) ticks++;
  // Twenty cycles a millisecond keeps every operation short
  scm_top #(.CYC_PER_MS(32'd20), .SAMPLE_DIV(16'h0020), .DRDY_W(8'h0a)) dut (
    .clk(clk), .rst(rst),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
    .spi_miso_oe_n(miso_oe_n), .line_in(lin), .line_out(lout), .line_oe_n(loe_n),
    .alarm_active(alarm_active), .st_fail(st_fail), .flash_sum_ok(flash_sum_ok),
    .sample_tick(tick), .st_excite(excite), .data_flush(flush));
  scm_host_model host (.clk(clk), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  task automatic complete_run();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({1'b1, a, d}, r);
  endtask
  // Answer arrives in the following frame
  task automatic rd(input logic [6:0] a, output logic [15:0] q);
    host.xfer({1'b0, a, 8'h00}, q);
    host.xfer(16'h0000, q);
  endtask
  task automatic clks(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wait_clr(input logic [7:0] m);
    for (n = 0; n < 40; n++) begin
      rd(`SCM_A_CMD, r);
      if ((r[7:0] & m) === 8'h00) break;
    end
    if (n == 40) begin
      err_count++;
      complete_run();
    end
  endtask
  initial begin
    clks(3);
    rst <= 1'b0;
    clks(4);
    cmp("oe_n", 16'h000d, {12'h000, loe_n});
    wr(`SCM_A_PAGE, `SCM_PG_CTRL);
    rd(`SCM_A_FNC, r);
    cmp("fnc", `SCM_FNC_RST, r);
    wr(7'h07, 8'h09);
    rd(`SCM_A_FNC, r);
    cmp("fnc", 16'h010d, r);
    wr(`SCM_A_FNC, 8'hdd);
    rd(`SCM_A_FNC, r);
    cmp("fnc", 16'h015d, r);
    // Every line code, both ready polarities
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 2; p++) begin
        wr(`SCM_A_FNC, {5'h01, p[0], s[1:0]});
        cmp("oe_n", {12'h000, ~(4'h1 << s)}, {12'h000, loe_n});
        for (n = 0; n < 200 && tick !== 1'b1; n++) @(negedge clk);
        if (n == 200) begin
          err_count++;
          complete_run();
        end
        clks(3);
        cmp("drdy", {15'h0000, p[0]}, {15'h0000, lout[s]});
      end
    end
    wr(`SCM_A_FNC, 8'h0d);
    wr(7'h07, 8'h0e);
    cmp("oe_n", 16'h0009, {12'h000, loe_n});
    for (int a = 1; a >= 0; a--) begin
      alarm_active <= a[0];
      clks(4);
      cmp("alarm", {15'h0000, a[0]}, {15'h0000, lout[2]});
    end
    wr(7'h07, 8'h00);
    pin_drv <= 4'h8;
    wr(`SCM_A_GPIO, 8'h15);
    cmp("oe_n", 16'h0008, {12'h000, loe_n});
    cmp("lout", 16'h0001, {12'h000, lout & 4'h5});
    wr(7'h09, 8'hff);
    rd(`SCM_A_GPIO, r);
    cmp("gpio", 16'h0095, r & 16'hffdf);
    rd(7'h40, r);
    cmp("unmapped", 16'h0000, r);
    wr(`SCM_A_CMD, 8'h02);
    rd(`SCM_A_CMD, r);
    cmp("cmd", 16'h0002, r);
    wait_clr(8'h02);
    wr(`SCM_A_PAGE, `SCM_PG_STATUS);
    rd(`SCM_A_DIAG, r);
    cmp("diag", 16'h00a5, r);
    wr(`SCM_A_PAGE, `SCM_PG_CTRL);
    flash_sum_ok <= 1'b0;
    foreach (ops[i]) begin
      wr(`SCM_A_CMD, ops[i]);
      wait_clr(ops[i]);
    end
    wr(`SCM_A_PAGE, `SCM_PG_STATUS);
    rd(`SCM_A_SYSERR, r);
    cmp("syserr", 16'h0040, r & 16'h0040);
    flash_sum_ok <= 1'b1;
    wr(`SCM_A_PAGE, `SCM_PG_CTRL);
    wr(`SCM_A_CMD, 8'h04);
    wait_clr(8'h04);
    wr(`SCM_A_PAGE, `SCM_PG_STATUS);
    rd(`SCM_A_SYSERR, r);
    cmp("syserr", 16'h0000, r & 16'h0040);
    wr(`SCM_A_PAGE, `SCM_PG_CTRL);
    wr(`SCM_A_FNC, 8'h0c);
    wr(`SCM_A_CMD, 8'h80);
    for (n = 0; n < 3000 && flush !== 1'b1; n++) @(negedge clk);
    if (n == 3000) begin
      err_count++;
      complete_run();
    end
    clks(10);
    wr(`SCM_A_PAGE, `SCM_PG_CTRL);
    rd(`SCM_A_FNC, r);
    cmp("fnc", 16'h000d, r);
    rd(`SCM_A_GPIO, r);
    cmp("dir", 16'h0005, r & 16'h000f);
    wr(`SCM_A_PAGE, `SCM_PG_FLASH);
    rd(`SCM_A_FCNT_LO, r);
    cmp("cnt_lo", 16'h0003, r);
    rd(`SCM_A_FCNT_HI, r);
    cmp("cnt_hi", 16'h0000, r);
    wr(`SCM_A_PAGE, `SCM_PG_CTRL);
    // External sample clock on line 4, both edges; line idles low
    pin_drv <= 4'h0;
    for (int e = 1; e >= 0; e--) begin
      wr(`SCM_A_FNC, {1'b1, e[0], 6'h3d});
      clks(10);
      n = ticks;
      clks(200);
      cmp("idle", 16'h0000, 16'(ticks - n));
      repeat (4) begin
        pin_drv[3] <= 1'b1;
        clks(4);
        pin_drv[3] <= 1'b0;
        clks(4);
      end
      clks(10);
      cmp("ticks", 16'h0004, 16'(ticks - n));
    end
    // Self-test under sync runs longer than on the internal clock
    wr(`SCM_A_CMD, 8'h02);
    clks(400);
    rd(`SCM_A_CMD, r);
    cmp("stext", 16'h0002, r);
    wait_clr(8'h02);
    complete_run();
  end
endmodule
`default_nettype wire
